// File: src/ecc_handler.v
// Purpose: error handling for memory cycles in all seven operating modes
// Assumes: memory returns data and checks the cycle after mem_rd
// Notes:   registers reached over AXI4-Lite, one aligned word each
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ecc_handler_defines.vh"

module ecc_handler (
    // clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // axi4-lite write
    input  wire [4:0]        awaddr,
    input  wire              awvalid,
    output reg               awready,
    input  wire [31:0]       wdata,
    input  wire [3:0]        wstrb,
    input  wire              wvalid,
    output reg               wready,
    output reg  [1:0]        bresp,
    output reg               bvalid,
    input  wire              bready,
    // axi4-lite read
    input  wire [4:0]        araddr,
    input  wire              arvalid,
    output reg               arready,
    output reg  [31:0]       rdata,
    output reg  [1:0]        rresp,
    output reg               rvalid,
    input  wire              rready,
    // processor bus cycles
    input  wire              cyc_valid,
    input  wire              cyc_write,
    input  wire              cyc_byte,
    input  wire              cyc_hi,
    input  wire [`AW-1:0]    cyc_addr,
    input  wire [15:0]       cyc_wdata,
    output reg               cyc_done,
    output reg  [15:0]       cyc_rdata,
    output reg               bus_error_data_line,
    // memory array
    output reg  [`AW-1:0]    mem_addr,
    output reg               mem_rd,
    output reg               mem_wr,
    output reg  [15:0]       mem_wdata,
    output reg  [5:0]        mem_wchk,
    input  wire [15:0]       mem_rdata,
    input  wire [5:0]        mem_rchk,
    // front panel
    output reg               led_red
);

    ////////////////////////////////////////////////////////////////////
    // state and storage

    localparam [3:0] S_IDLE  = 4'h1;
    localparam [3:0] S_FETCH = 4'h2;
    localparam [3:0] S_EVAL  = 4'h4;
    localparam [3:0] S_HOLD  = 4'h8;

    reg  [3:0]      state_r;
    reg  [15:0]     csr_r;
    reg  [15:0]     csr_nxt;
    reg  [`AW-1:0]  erraddr_r;
    reg  [4:0]      synd_r;
    reg  [`AW-1:0]  req_addr_r;
    reg  [15:0]     req_data_r;
    reg             req_write_r;
    reg             req_hi_r;
    reg             aw_got_r;
    reg             w_got_r;
    reg  [4:0]      awad_r;
    reg  [15:0]     wdat_r;
    reg  [1:0]      wstb_r;

    ////////////////////////////////////////////////////////////////////
    // mode decode

    wire       diag   = csr_r[`CSR_DIAG];
    wire       eccdis = csr_r[`CSR_ECCDIS];
    wire       prot   = csr_r[`CSR_PROT];
    wire       idle   = state_r == S_IDLE;
    wire [`AW-1:0] cur_addr = idle ? cyc_addr : req_addr_r;

    // only the low 32 kW holds the two candidate blocks
    wire in_blk = (cur_addr[`AW-1:`BLK_BIT+1] == {(`AW-`BLK_BIT-1){1'b0}})
                & (cur_addr[`BLK_BIT] == csr_r[`CSR_BLKSEL]);  // see [R15]
    wire shield = prot & in_blk;                               // see [R1]

    // the shield overrides diagnostic and ECC-off behaviour
    wire eff_diag = diag & ~shield;                 // see [R2] see [R12]
    wire eff_dis  = eccdis & ~shield;               // see [R2]
    wire log_ok   = ~diag & ~shield;                // see [R5]

    reg [2:0] mode_code;

    always @* begin  // see [R14] see [R16]
        case ({prot, diag, eccdis})
            3'b000:  mode_code = `MODE_NORM_EN;
            3'b001:  mode_code = `MODE_NORM_DIS;
            3'b101:  mode_code = `MODE_PNRM_DIS;
            3'b010:  mode_code = `MODE_DIAG_EN;
            3'b011:  mode_code = `MODE_DIAG_DIS;
            3'b110:  mode_code = `MODE_PDIA_EN;
            3'b111:  mode_code = `MODE_PDIA_DIS;
            default: mode_code = `MODE_NORM_EN;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // check and generate

    wire [15:0] fixed;
    wire        se;
    wire        de;
    wire [4:0]  syn;

    ecc_decode u_dec (
        .data   (mem_rdata),
        .chk    (mem_rchk),
        .fixed  (fixed),
        .single (se),
        .double (de),
        .syn    (syn)
    );

    // single errors are left raw only where ECC is off and unshielded
    wire        fix_rd = se & ~eff_dis;                        // see [R4]
    wire [15:0] old_w  = se ? fixed : mem_rdata;
    wire [15:0] merged = req_hi_r ? {req_data_r[15:8], old_w[7:0]}
                                  : {old_w[15:8], req_data_r[7:0]};
    wire [15:0] enc_in = idle ? cyc_wdata : merged;
    wire [5:0]  gen_chk;

    ecc_encode u_enc (
        .data (enc_in),
        .chk  (gen_chk)
    );

    wire [5:0] csr_cb = csr_r[`CSR_CB_HI:`CSR_CB_LO];
    // status check bits only ever reach unshielded memory
    wire [5:0] wr_chk = eff_diag ? csr_cb : gen_chk;  // see [R11]

    ////////////////////////////////////////////////////////////////////
    // hardware flag events, valid in the evaluate cycle

    wire ev    = state_r == S_EVAL;
    wire ev_rd = ev & ~req_write_r;
    wire ev_wb = ev & req_write_r;
    wire uncor = se & eff_dis;

    wire hw_set4  = (ev_rd & se)                        // see [R4]
                  | (ev_wb & se & ~eff_diag);           // see [R7] see [R13]
    wire hw_set15 = (ev_rd & (de | uncor))              // see [R6]
                  | (ev_wb & se & eff_dis & ~eff_diag);
    // shielded cycles never capture check bits
    wire hw_cb    = ev_rd & eff_diag;                   // see [R3] see [R2]
    wire hw_log   = log_ok & ((ev_rd & (se | de))
                  | (ev_wb & se));                      // see [R13]

    ////////////////////////////////////////////////////////////////////
    // axi4-lite write side

    wire aw_hs = awvalid & awready;
    wire w_hs  = wvalid & wready;
    wire do_wr = aw_got_r & w_got_r & ~bvalid;
    wire wr_ok = awad_r[1:0] == 2'h0 && awad_r <= `OFS_MODE;
    wire csr_we = do_wr && awad_r == `OFS_CSR;
    wire [15:0] lane = {{8{wstb_r[1]}}, {8{wstb_r[0]}}} & `CSR_WMASK;

    always @* begin
        csr_nxt = csr_r;
        if (csr_we) begin
            csr_nxt = (csr_r & ~lane) | (wdat_r & lane);
        end
        // a hardware set in the clearing cycle wins
        if (hw_cb) begin
            csr_nxt[`CSR_CB_HI:`CSR_CB_LO] = mem_rchk;  // see [R17]
        end
        if (hw_set4) begin
            csr_nxt[`CSR_SERR] = 1'b1;                  // see [R18]
        end
        if (hw_set15) begin
            csr_nxt[`CSR_DERR] = 1'b1;                  // see [R18]
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= `RESP_OKAY;
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            awad_r   <= 5'h00;
            wdat_r   <= 16'h0000;
            wstb_r   <= 2'h0;
        end else begin
            awready <= ~(aw_got_r | aw_hs) & ~do_wr;
            wready  <= ~(w_got_r | w_hs) & ~do_wr;
            if (aw_hs) begin
                aw_got_r <= 1'b1;
                awad_r   <= awaddr;
            end
            if (w_hs) begin
                w_got_r <= 1'b1;
                wdat_r  <= wdata[15:0];
                wstb_r  <= wstrb[1:0];
            end
            if (do_wr) begin
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
                bvalid   <= 1'b1;
                bresp    <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (bvalid & bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // axi4-lite read side

    wire ar_hs = arvalid & arready;

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `RESP_OKAY;
        end else begin
            arready <= ~(rvalid | ar_hs);
            if (ar_hs) begin
                rvalid <= 1'b1;
                rresp  <= `RESP_OKAY;
                case (araddr)
                    `OFS_CSR:     rdata <= {16'h0000, csr_r};
                    `OFS_ERRADDR: rdata <= {{(32-`AW){1'b0}}, erraddr_r};
                    `OFS_SYND:    rdata <= {27'h0000000, synd_r};
                    `OFS_MODE:    rdata <= {29'h00000000, mode_code};
                    default: begin
                        rdata <= 32'h00000000;
                        rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (rvalid & rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status, log and lamp

    always @(posedge aclk) begin
        if (!aresetn) begin
            csr_r     <= `CSR_RST;
            erraddr_r <= {`AW{1'b0}};
            synd_r    <= 5'h00;
            led_red   <= 1'b0;
        end else begin
            csr_r   <= csr_nxt;
            // lamp follows the uncorrectable flag
            led_red <= csr_nxt[`CSR_DERR];              // see [R6]
            if (hw_log) begin
                erraddr_r <= req_addr_r;
                synd_r    <= syn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // cycle sequencer

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r             <= S_IDLE;
            req_addr_r          <= {`AW{1'b0}};
            req_data_r          <= 16'h0000;
            req_write_r         <= 1'b0;
            req_hi_r            <= 1'b0;
            mem_addr            <= {`AW{1'b0}};
            mem_rd              <= 1'b0;
            mem_wr              <= 1'b0;
            mem_wdata           <= 16'h0000;
            mem_wchk            <= 6'h00;
            cyc_done            <= 1'b0;
            cyc_rdata           <= 16'h0000;
            bus_error_data_line <= 1'b0;
        end else begin
            mem_rd              <= 1'b0;
            mem_wr              <= 1'b0;
            cyc_done            <= 1'b0;
            bus_error_data_line <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (cyc_valid) begin
                        req_addr_r  <= cyc_addr;
                        req_data_r  <= cyc_wdata;
                        req_write_r <= cyc_write;
                        req_hi_r    <= cyc_hi;
                        mem_addr    <= cyc_addr;
                        if (cyc_write & ~cyc_byte) begin
                            mem_wr    <= 1'b1;
                            mem_wdata <= cyc_wdata;
                            mem_wchk  <= wr_chk;        // see [R10]
                            cyc_done  <= 1'b1;
                            state_r   <= S_HOLD;
                        end else begin
                            // byte writes read the old word first
                            mem_rd  <= 1'b1;
                            state_r <= S_FETCH;
                        end
                    end
                end
                S_FETCH: begin
                    state_r <= S_EVAL;
                end
                S_EVAL: begin
                    cyc_done <= 1'b1;
                    state_r  <= S_HOLD;
                    if (!req_write_r) begin
                        cyc_rdata <= fix_rd ? fixed : mem_rdata;
                        bus_error_data_line <= de | uncor;  // see [R6]
                    end else begin
                        mem_wr <= 1'b1;
                        if (de & ~eff_diag) begin
                            // keep the bad word so the next read fails
                            mem_wdata <= mem_rdata;     // see [R8] see [R9]
                            mem_wchk  <= mem_rchk;      // see [R8]
                        end else begin
                            mem_wdata <= merged;        // see [R7]
                            mem_wchk  <= wr_chk;        // see [R7] see [R11]
                        end
                    end
                end
                S_HOLD: begin
                    // gives the master a cycle to drop its request
                    state_r <= S_IDLE;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

endmodule // ecc_handler

`default_nettype wire

// File: src/ecc_handler_defines.vh
// Purpose: constants for the protected block error handler
// Assumes: 16-bit memory words, six check bits, 32 kW low window
// Notes:   included by every design file of the handler
//
// How it works
// [R1] protect mode shields one 16 kW block; it acts as normal mode, ECC on
// [R2] shielded block always corrects single errors, never latches check bits
// [R3] clean shielded read returns memory data, status check bits untouched
// [R4] shielded single read error sets status bit 4, corrects bus data
// [R5] shielded single read error logs no address and no syndrome
// [R6] shielded double read error: bit 15, red lamp, error line, no latch
// [R7] shielded byte write single error: bit 4, correct, merge, new ECC
// [R8] shielded byte write double error: old data and check bits back
// [R9] the rewritten bad word fails again on the next read there
// [R10] shielded word write stores data with generated check bits
// [R11] status check bits are never written into the shielded block
// [R12] in protected modes status check bits serve only unshielded memory
// [R13] normal byte write single error: bit 4, correct, log, ECC bits
// [R14] seven operating modes, each with its own per-cycle handling
// [R15] status bit 3 picks which 16 kW block is shielded
// [R16] software sets bit 2 and clears bit 14 for diagnostic mode
// [R17] status bits 5..10 hold cbx, cb0, cb1, cb2, cb4, cb8
// [R18] bits 4 and 15 stay set until software write or reset
`ifndef ECC_HANDLER_DEFINES_VH
`define ECC_HANDLER_DEFINES_VH

// register byte offsets
`define OFS_CSR      5'h00
`define OFS_ERRADDR  5'h04
`define OFS_SYND     5'h08
`define OFS_MODE     5'h0C

// status register fields
`define CSR_DIAG     2
`define CSR_BLKSEL   3
`define CSR_SERR     4
`define CSR_CB_LO    5
`define CSR_CB_HI    10
`define CSR_PROT     13
`define CSR_ECCDIS   14
`define CSR_DERR     15
`define CSR_WMASK    16'hE7FC
`define CSR_RST      16'h0000

// memory geometry
`define AW           18
`define BLK_BIT      14

// hamming position of each data bit, 5 bits per entry, bit 0 first
`define ECC_POS {5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h0F, 5'h0E, \
                 5'h0D, 5'h0C, 5'h0B, 5'h0A, 5'h09, 5'h07, 5'h06, \
                 5'h05, 5'h03}

// mode codes
`define MODE_NORM_EN  3'h0
`define MODE_NORM_DIS 3'h1
`define MODE_PNRM_DIS 3'h2
`define MODE_DIAG_EN  3'h3
`define MODE_DIAG_DIS 3'h4
`define MODE_PDIA_EN  3'h5
`define MODE_PDIA_DIS 3'h6

// bus responses
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// File: src/ecc_encode.v
// Purpose: check bit generator for one 16-bit word
// Assumes: chk[0] is the cross bit, chk[5:1] are cb0..cb8
// Notes:   cross bit makes the parity of data plus all checks even
`timescale 1ns/1ns
`default_nettype none
`include "ecc_handler_defines.vh"

module ecc_encode (
    // word in
    input  wire [15:0] data,
    // check bits out
    output wire [5:0]  chk
);

    localparam [79:0] POS = `ECC_POS;

    reg     [4:0] ham;
    integer       i;
    integer       k;

    always @* begin
        ham = 5'h00;
        for (i = 0; i < 16; i = i + 1) begin
            for (k = 0; k < 5; k = k + 1) begin
                if (POS[i*5+k]) begin
                    ham[k] = ham[k] ^ data[i];
                end
            end
        end
    end

    assign chk = {ham, ^{data, ham}};  // see [R17]

endmodule // ecc_encode

`default_nettype wire

// File: src/ecc_decode.v
// Purpose: checks a stored word and corrects a single bit error
// Assumes: check bit order as in ecc_encode
// Notes:   a bad cross bit alone is a single error with clean data
`timescale 1ns/1ns
`default_nettype none
`include "ecc_handler_defines.vh"

module ecc_decode (
    // stored word
    input  wire [15:0] data,
    input  wire [5:0]  chk,
    // result
    output reg  [15:0] fixed,
    output wire        single,
    output wire        double,
    output wire [4:0]  syn
);

    localparam [79:0] POS = `ECC_POS;

    wire    [5:0] gen;
    integer       i;

    ecc_encode u_enc (
        .data (data),
        .chk  (gen)
    );

    assign syn    = gen[5:1] ^ chk[5:1];
    assign single = ^{data, chk};
    assign double = ~single & (syn != 5'h00);

    always @* begin
        fixed = data;
        for (i = 0; i < 16; i = i + 1) begin
            if (single && (POS[i*5 +: 5] == syn)) begin
                fixed[i] = ~data[i];
            end
        end
    end

endmodule // ecc_decode

`default_nettype wire

// File: test/ecc_handler_assertions.sv
// Purpose: port level checks on the protected block error handler
// Assumes: one processor cycle at a time, cyc_valid held until cyc_done
// Notes:   status bits are not ports; modes are checked by the bench
`timescale 1ns/1ns
`default_nettype none
`include "ecc_handler_defines.vh"
////////////////////////////////////////////////////////////////////////
module ecc_handler_checker (
    // clock and reset
    input wire logic           aclk,
    input wire logic           aresetn,
    // register bus
    input wire logic           wvalid,
    input wire logic           arvalid,
    input wire logic           arready,
    input wire logic           rvalid,
    input wire logic           rready,
    input wire logic [31:0]    rdata,
    // processor cycle
    input wire logic           cyc_valid,
    input wire logic           cyc_write,
    input wire logic           cyc_byte,
    input wire logic [`AW-1:0] cyc_addr,
    input wire logic           cyc_done,
    input wire logic           bus_error_data_line,
    // memory and panel
    input wire logic [`AW-1:0] mem_addr,
    input wire logic           mem_rd,
    input wire logic           mem_wr,
    input wire logic           led_red
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_word_wr;
        $rose(cyc_valid) && cyc_write && !cyc_byte |=> mem_wr && cyc_done;
    endproperty
    a_word_wr: assert property (p_word_wr)
        else $error("word write late");
    property p_byte_wr;
        $rose(cyc_valid) && cyc_write && cyc_byte |=>
            mem_rd ##2 (cyc_done && mem_wr);
    endproperty
    a_byte_wr: assert property (p_byte_wr)
        else $error("byte write order");
    property p_read;
        $rose(cyc_valid) && !cyc_write |=> mem_rd ##2 (cyc_done && !mem_wr);
    endproperty
    a_read: assert property (p_read)
        else $error("read order");
    property p_done_once;
        cyc_done |=> !cyc_done && !mem_wr;
    endproperty
    a_done_once: assert property (p_done_once)
        else $error("done too long");
    property p_err_on_read;
        bus_error_data_line |-> cyc_done && !mem_wr;
    endproperty
    a_err_on_read: assert property (p_err_on_read)
        else $error("stray error line");
    property p_led_on;
        bus_error_data_line |-> ##[1:2] led_red;
    endproperty
    a_led_on: assert property (p_led_on)
        else $error("lamp not lit");
    property p_led_keep;
        $fell(led_red) |-> $past(wvalid) || $past(wvalid, 2)
            || $past(wvalid, 3);
    endproperty
    a_led_keep: assert property (p_led_keep)
        else $error("lamp dropped");
    property p_wr_addr;
        mem_wr |-> mem_addr == cyc_addr;
    endproperty
    a_wr_addr: assert property (p_wr_addr)
        else $error("write address");
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("rdata dropped");
    property p_r_answer;
        arvalid && arready |=> rvalid;
    endproperty
    a_r_answer: assert property (p_r_answer)
        else $error("read answer late");
    c_err: cover property (bus_error_data_line);
    c_byte: cover property (mem_rd ##2 mem_wr);
    c_led_off: cover property ($fell(led_red));
endmodule // ecc_handler_checker
////////////////////////////////////////////////////////////////////////
bind ecc_handler ecc_handler_checker checker_i (.*);
`default_nettype wire

// File: test/mem_model.sv
// Purpose: memory array behind the error handler, data plus check bits
// Assumes: index built from address bit 14 and bits 5:0
// Notes:   read data held two edges, then toggles so stale data shows
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
module mem_model (
    // clock
    input wire logic        aclk,
    // memory port
    input wire logic [17:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [15:0] mem_wdata,
    input wire logic [5:0]  mem_wchk,
    output var logic [15:0] mem_rdata,
    output var logic [5:0]  mem_rchk
);
    logic [21:0] mem [0:127];
    logic [1:0]  hold_r;
    logic [6:0]  idx;
    assign idx = {mem_addr[14], mem_addr[5:0]};
    initial begin
        for (int i = 0; i < 128; i++) mem[i] = 22'h000000;
        {mem_rchk, mem_rdata} = 22'h000000;
        hold_r = 2'h0;
    end
    always @(posedge aclk) begin
        // a rewritten bad word stays bad for the next read
        if (mem_wr) mem[idx] <= {mem_wchk, mem_wdata};
        if (mem_rd) begin
            {mem_rchk, mem_rdata} <= mem[idx];
            hold_r <= 2'h2;
        end else if (hold_r > 2'h1) begin
            hold_r <= hold_r - 2'h1;
        end else begin
            {mem_rchk, mem_rdata} <= ~{mem_rchk, mem_rdata};
            hold_r <= 2'h0;
        end
    end
endmodule // mem_model
`default_nettype wire

// File: test/protected_block_ecc_error_handler_test.sv
// Purpose: self-checking bench for the protected block error handler
// Assumes: bench drives register bus and processor cycles
// Notes:   bready stays high, so write responses go at once
`timescale 1ns/1ns
`default_nettype none
`include "ecc_handler_defines.vh"
////////////////////////////////////////////////////////////////////////
module protected_block_ecc_error_handler_test;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b1, arvalid = 1'b0, rready = 1'b0;
    logic cyc_valid = 1'b0, cyc_write = 1'b0, cyc_byte = 1'b0;
    logic cyc_hi = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic [`AW-1:0] cyc_addr = 18'h00000, mem_addr;
    logic [15:0] cyc_wdata = 16'h0000, cyc_rdata, mem_wdata, mem_rdata;
    logic awready, wready, bvalid, arready, rvalid, cyc_done, mem_rd;
    logic mem_wr, led_red, bus_error_data_line;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [5:0] mem_wchk, mem_rchk;
    logic [15:0] q;
    logic be;
    logic [21:0] sv;
    integer fail_count = 0, n_tests = 0, i;
    logic [111:0] md = 112'h6004200440040004600040000000;
    always #50 aclk = ~aclk;
    ecc_handler dut (.*);
    mem_model mdl (.*);
    ////////////////////////////////////////////////////////////////////
    function automatic logic [5:0] enc(input logic [15:0] dd);
        logic [79:0] p;
        logic [5:0] c;
        p = `ECC_POS;
        c = 6'h00;
        for (int j = 0; j < 16; j++)
            for (int k = 0; k < 5; k++)
                if (p[j*5+k]) c[k+1] = c[k+1] ^ dd[j];
        c[0] = ^{dd, c[5:1]};
        return c;
    endfunction
    task print_verdict();
        $display("tests %0d errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tmo(input integer n);
        if (n >= 40) begin
            fail_count++;
            $display("Error wait expected done seen none");
            print_verdict();
        end
    endtask
    task axi_wr(input logic [4:0] a, input logic [31:0] dv,
                output logic [1:0] rv);
        integer n;
        logic ad, dd;
        awaddr <= a;
        wdata <= dv;
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        ad = 1'b0;
        dd = 1'b0;
        for (n = 0; n < 40 && !(ad && dd); n++) begin
            @(posedge aclk);
            ad = ad | awready;
            dd = dd | wready;
            awvalid <= !ad;
            wvalid <= !dd;
        end
        tmo(n);
        for (n = 0; n < 40 && !bvalid; n++) @(posedge aclk);
        tmo(n);
        rv = bresp;
    endtask
    task axi_rd(input logic [4:0] a, output logic [31:0] dv,
                output logic [1:0] rv);
        integer n;
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge aclk);
        for (n = 1; n < 40 && !arready; n++) @(posedge aclk);
        tmo(n);
        arvalid <= 1'b0;
        for (n = 0; n < 40 && !rvalid; n++) @(posedge aclk);
        tmo(n);
        rready <= 1'b1;
        @(posedge aclk);
        dv = rdata;
        rv = rresp;
        rready <= 1'b0;
    endtask
    task reg_is(input logic [4:0] a, input logic [31:0] e);
        axi_rd(a, d, r);
        chk("register", e, d);
    endtask
    task cyc(input logic w, input logic b, input logic h,
             input logic [17:0] a, input logic [15:0] wd);
        integer n;
        cyc_valid <= 1'b1;
        cyc_write <= w;
        cyc_byte <= b;
        cyc_hi <= h;
        cyc_addr <= a;
        cyc_wdata <= wd;
        for (n = 0; n < 40 && !cyc_done; n++) @(posedge aclk);
        tmo(n);
        q = cyc_rdata;
        be = bus_error_data_line;
        cyc_valid <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_is(`OFS_CSR, 32'h0);
        axi_rd(5'h10, d, r);
        chk("unmapped rresp", `RESP_SLVERR, r);
        axi_wr(5'h02, 32'h4, r);
        chk("misaligned bresp", `RESP_SLVERR, r);
        for (i = 0; i < 7; i++) begin
            axi_wr(`OFS_CSR, {16'h0, md[i*16 +: 16]}, r);
            reg_is(`OFS_MODE, i);
        end
        axi_wr(`OFS_CSR, 32'h6544, r);
        cyc(1, 0, 0, 18'h10, 16'h1234);
        chk("stored word", {enc(16'h1234), 16'h1234}, mdl.mem[7'h10]);
        cyc(0, 0, 0, 18'h10, 16'h0);
        chk("read data", 16'h1234, q);
        reg_is(`OFS_CSR, 32'h6544);
        mdl.mem[7'h10] ^= 22'h8;
        cyc(0, 0, 0, 18'h10, 16'h0);
        chk("corrected data", 16'h1234, q);
        chk("error line", 1'b0, be);
        reg_is(`OFS_CSR, 32'h6554);
        reg_is(`OFS_ERRADDR, 32'h0);
        reg_is(`OFS_SYND, 32'h0);
        cyc(1, 1, 0, 18'h10, 16'h00AB);
        chk("merged word", {enc(16'h12AB), 16'h12AB}, mdl.mem[7'h10]);
        axi_wr(`OFS_CSR, 32'h6544, r);
        reg_is(`OFS_CSR, 32'h6544);
        cyc(1, 0, 0, 18'h20, 16'h5555);
        mdl.mem[7'h20] ^= 22'h3;
        sv = mdl.mem[7'h20];
        cyc(1, 1, 1, 18'h20, 16'hCC00);
        chk("kept word", sv, mdl.mem[7'h20]);
        reg_is(`OFS_CSR, 32'h6544);
        cyc(0, 0, 0, 18'h20, 16'h0);
        chk("error line", 1'b1, be);
        reg_is(`OFS_CSR, 32'hE544);
        chk("red lamp", 1'b1, led_red);
        axi_wr(`OFS_CSR, 32'h654C, r);
        reg_is(`OFS_CSR, 32'h654C);
        chk("red lamp", 1'b0, led_red);
        cyc(1, 0, 0, 18'h10, 16'h0F0F);
        chk("test word", 22'h2A0F0F, mdl.mem[7'h10]);
        cyc(1, 0, 0, 18'h4010, 16'h0F0F);
        chk("shielded word", {enc(16'h0F0F), 16'h0F0F}, mdl.mem[7'h50]);
        axi_wr(`OFS_CSR, 32'h0, r);
        cyc(1, 0, 0, 18'h30, 16'h00FF);
        mdl.mem[7'h30] ^= 22'h8;
        cyc(1, 1, 0, 18'h30, 16'h0011);
        chk("normal merge", {enc(16'h0011), 16'h0011}, mdl.mem[7'h30]);
        reg_is(`OFS_CSR, 32'h10);
        reg_is(`OFS_ERRADDR, 32'h30);
        reg_is(`OFS_SYND, 32'h07);
        print_verdict();
    end
endmodule // protected_block_ecc_error_handler_test
`default_nettype wire
